// ==== verilog/psw_pkg.sv ====
// package: constants, types and register map of the processor supervision watchdog
package psw_pkg;
    // ==========================================================
    // clock and timing
    // ==========================================================
    localparam int          CLK_HZ          = 20_000_000;
    localparam int          RESTORE_US      = 250;       // restoration time after overrun
    localparam int          RESTORE_CYC     = (RESTORE_US * (CLK_HZ / 1_000_000));
    localparam int          AUTO_SVC_MS     = 30;        // firmware auto service interval
    localparam int          AUTO_SVC_CYC    = AUTO_SVC_MS * (CLK_HZ / 1000);
    localparam int          PERIOD_W        = 32;        // period counted in clock cycles
    // ==========================================================
    // service sequence
    // ==========================================================
    localparam logic [31:0] SVC_WORD0       = 32'h0000_a55a;
    localparam logic [31:0] SVC_WORD1       = 32'h0000_5aa5;
    // ==========================================================
    // device-side link commands
    // ==========================================================
    typedef enum logic [2:0] {
        PSW_CMD_SERVICE = 3'h0,
        PSW_CMD_SETCFG  = 3'h1,
        PSW_CMD_SETPER  = 3'h2,
        PSW_CMD_LOCK    = 3'h3,
        PSW_CMD_ACK     = 3'h4,
        PSW_CMD_IRQEN   = 3'h5
    } psw_cmd_e;
    // event configuration
    typedef enum logic [1:0] {
        PSW_EV_OFF   = 2'h0,
        PSW_EV_IRQ   = 2'h1,
        PSW_EV_RESET = 2'h2
    } psw_ev_e;
    // ==========================================================
    // controller registers on APB (byte offsets)
    // ==========================================================
    localparam logic [7:0]  REG_CTRL        = 8'h00; // [0] auto service enable
    localparam logic [7:0]  REG_CMD         = 8'h04; // [2:0] cmd, write issues
    localparam logic [7:0]  REG_DATA        = 8'h08; // command data
    localparam logic [7:0]  REG_STAT        = 8'h0c; // device state readback
    localparam logic [7:0]  REG_IRQ_STAT    = 8'h10; // sticky events, write one clears
    localparam logic [7:0]  REG_IRQ_MASK    = 8'h14;
    localparam int          IRQ_CMDDONE     = 0;
    localparam int          IRQ_WDIRQ       = 1;
    localparam int          IRQ_W           = 2;
    localparam logic        CTRL_RST        = 1'b0;
endpackage : psw_pkg

// ==== verilog/psw_link_if.sv ====
// interface: link between watchdog device and supervising controller
`timescale 1ns/1ns
interface psw_link_if;
    import psw_pkg::*;
    logic        cmdValid;
    psw_cmd_e    cmdCode;
    logic [31:0] cmdData;
    logic        cmdAccepted;
    logic        wdIrq;          // latched watchdog_irq_source_line
    logic        wdReset;        // reset event toward the processor
    logic        safetyMode;
    logic        overrun;
    modport dev  (input cmdValid, cmdCode, cmdData,
                  output cmdAccepted, wdIrq, wdReset, safetyMode, overrun);
    modport host (output cmdValid, cmdCode, cmdData,
                  input cmdAccepted, wdIrq, wdReset, safetyMode, overrun);
endinterface : psw_link_if

// ==== verilog/psw_watchdog.sv ====
// module: processor supervision watchdog device
// Operation
// - processor writes service sequence before expiry
// - expiry without service triggers selected event
// - two modes: safety and flexible
// - flexible mode: event and period reconfigurable
// - event setting off disables watchdog
// - safety mode locks config, left only on reset
// - processor services before locking safety mode
// - powerup: flexible mode, supervision off
// - firmware auto services every 30 ms
// - event option raises processor interrupt
// - interrupt pollable and routable to controller
// - interrupt latched until processor acknowledges
// - fast irq enable gates propagation only
// - overrun self restores after 250 us
// - service during restoration ends overrun early
//
// The APB interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ns
module psw_watchdog
    import psw_pkg::*;
(
    input  wire logic   clock,
    input  wire logic   rst,
    psw_link_if.dev     link,
    output logic        irqToController,
    output logic [31:0] countNow
);
    // ==========================================================
    // state
    // ==========================================================
    typedef struct packed {
        logic                safety;
        psw_ev_e             ev;
        logic [PERIOD_W-1:0] period;
        logic [PERIOD_W-1:0] cnt;
        logic                seqHalf;   // first sequence word seen
        logic                irqLatch;
        logic                irqEn;
        logic                ovr;
        logic [15:0]         restCnt;
        logic                resetPulse;
    } psw_dev_s;

    psw_dev_s state_q;
    psw_dev_s state_d;
    logic     svcOk;
    logic     canCfg;

    // ==========================================================
    // next state
    // ==========================================================
    always_comb begin
        state_d            = state_q;
        state_d.resetPulse = 1'b0;
        svcOk              = 1'b0;
        canCfg             = !state_q.safety;
        if (link.cmdValid) begin
            case (link.cmdCode)
                PSW_CMD_SERVICE: begin
                    if (!state_q.seqHalf && link.cmdData == SVC_WORD0) begin
                        state_d.seqHalf = 1'b1;
                    end else if (state_q.seqHalf && link.cmdData == SVC_WORD1) begin
                        state_d.seqHalf = 1'b0;
                        svcOk           = 1'b1;
                    end else begin
                        state_d.seqHalf = 1'b0;
                    end
                end
                PSW_CMD_SETCFG: if (canCfg) begin
                    state_d.ev = psw_ev_e'(link.cmdData[1:0]);
                    state_d.cnt = state_q.period;
                end
                PSW_CMD_SETPER: if (canCfg) begin
                    state_d.period = link.cmdData;
                    state_d.cnt    = link.cmdData;
                end
                PSW_CMD_LOCK: begin
                    state_d.safety = 1'b1;
                end
                PSW_CMD_ACK: begin
                    state_d.irqLatch = 1'b0;
                end
                PSW_CMD_IRQEN: begin
                    state_d.irqEn = link.cmdData[0];
                end
                default: begin
                end
            endcase
        end
        // period countdown
        if (state_q.ev == PSW_EV_OFF) begin
            state_d.cnt = state_q.period;
            state_d.ovr = 1'b0;
        end else if (svcOk) begin
            state_d.cnt = state_q.period;
            state_d.ovr = 1'b0;
        end else if (state_q.ovr) begin
            if (state_q.restCnt == 16'h0001) begin
                state_d.ovr = 1'b0;
                state_d.cnt = state_q.period;
            end else begin
                state_d.restCnt = state_q.restCnt - 16'h0001;
            end
        end else if (state_q.cnt <= 32'h0000_0001) begin
            state_d.ovr     = 1'b1;
            state_d.restCnt = 16'(RESTORE_CYC);
            if (state_q.ev == PSW_EV_IRQ) begin
                state_d.irqLatch = 1'b1;
            end else begin
                state_d.resetPulse = 1'b1;
            end
        end else begin
            state_d.cnt = state_q.cnt - 32'h0000_0001;
        end
    end

    // register, powerup flexible and off
    always_ff @(posedge clock) begin
        if (rst) begin
            state_q <= '{safety: 1'b0, ev: PSW_EV_OFF, period: '1, cnt: '1,
                         seqHalf: 1'b0, irqLatch: 1'b0, irqEn: 1'b1, ovr: 1'b0,
                         restCnt: 16'h0000, resetPulse: 1'b0};
        end else begin
            state_q <= state_d;
        end
    end

    // outputs
    assign link.cmdAccepted = link.cmdValid;
    assign link.wdIrq       = state_q.irqLatch;
    assign link.wdReset     = state_q.resetPulse;
    assign link.safetyMode  = state_q.safety;
    assign link.overrun     = state_q.ovr;
    assign irqToController  = state_q.irqLatch & state_q.irqEn;
    assign countNow         = state_q.cnt;
endmodule : psw_watchdog

// ==== verilog/psw_host.sv ====
// module: APB controller that drives the watchdog link for the processor
`timescale 1ns/1ns
module psw_host
    import psw_pkg::*;
(
    input  wire logic   clock,
    input  wire logic   rst,
    input  wire logic   psel,
    input  wire logic   penable,
    input  wire logic   pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic        pready,
    output logic        pslverr,
    output logic        irq,
    psw_link_if.host    link
);
    // ==========================================================
    // state
    // ==========================================================
    typedef struct packed {
        logic              autoEn;
        logic [2:0]        cmd;
        logic [31:0]       data;
        logic              pend;
        logic [1:0]        autoStep;   // 0 idle, 1 word0, 2 word1
        logic [31:0]       autoCnt;
        logic [IRQ_W-1:0]  ist;
        logic [IRQ_W-1:0]  imask;
        logic              irqSeen;
        logic [31:0]       rdata;
    } psw_host_s;

    psw_host_s s_q;
    psw_host_s s_d;
    logic      wr;
    logic      rd;
    logic      done;
    logic [IRQ_W-1:0] evt;

    // next state
    always_comb begin
        s_d     = s_q;
        wr      = psel && penable && pwrite;
        rd      = psel && !penable && !pwrite;
        done    = link.cmdAccepted && link.cmdValid;
        evt     = '0;
        if (done && s_q.pend) evt[IRQ_CMDDONE] = 1'b1;
        if (link.wdIrq && !s_q.irqSeen) evt[IRQ_WDIRQ] = 1'b1;
        s_d.irqSeen = link.wdIrq;
        if (done) begin
            if (s_q.pend) s_d.pend = 1'b0;
            else if (s_q.autoStep == 2'h1) s_d.autoStep = 2'h2;
            else s_d.autoStep = 2'h0;
        end
        // auto service every 30 ms
        if (s_q.autoEn && s_q.autoCnt >= 32'(AUTO_SVC_CYC - 1)) begin
            s_d.autoCnt = 32'h0;
            if (s_q.autoStep == 2'h0) s_d.autoStep = 2'h1;
        end else begin
            s_d.autoCnt = s_q.autoEn ? s_q.autoCnt + 32'h1 : 32'h0;
        end
        if (wr) begin
            case (paddr)
                REG_CTRL:     s_d.autoEn = pwdata[0];
                REG_DATA:     s_d.data   = pwdata;
                REG_CMD: begin
                    s_d.cmd  = pwdata[2:0];
                    s_d.pend = 1'b1;
                end
                REG_IRQ_STAT: s_d.ist   = s_q.ist & ~pwdata[IRQ_W-1:0];
                REG_IRQ_MASK: s_d.imask = pwdata[IRQ_W-1:0];
                default: begin
                end
            endcase
        end
        s_d.ist = s_d.ist | evt;                            // set wins over clear
        if (rd) begin
            case (paddr)
                REG_CTRL:     s_d.rdata = {31'h0, s_q.autoEn};
                REG_CMD:      s_d.rdata = {28'h0, s_q.pend, s_q.cmd};
                REG_DATA:     s_d.rdata = s_q.data;
                REG_STAT:     s_d.rdata = {28'h0, link.overrun, link.safetyMode,
                                           link.wdReset, link.wdIrq};
                REG_IRQ_STAT: s_d.rdata = {30'h0, s_q.ist};
                REG_IRQ_MASK: s_d.rdata = {30'h0, s_q.imask};
                default:      s_d.rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            s_q <= '{autoEn: CTRL_RST, cmd: 3'h0, data: 32'h0, pend: 1'b0,
                     autoStep: 2'h0, autoCnt: 32'h0, ist: '0, imask: '0,
                     irqSeen: 1'b0, rdata: 32'h0};
        end else begin
            s_q <= s_d;
        end
    end

    // link drive: pending software command first, then auto service words
    assign link.cmdValid = s_q.pend || (s_q.autoStep != 2'h0);
    assign link.cmdCode  = s_q.pend ? psw_cmd_e'(s_q.cmd) : PSW_CMD_SERVICE;
    assign link.cmdData  = s_q.pend ? s_q.data :
                           (s_q.autoStep == 2'h1 ? SVC_WORD0 : SVC_WORD1);
    assign prdata  = s_q.rdata;
    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    assign irq     = |(s_q.ist & s_q.imask);
endmodule : psw_host

// ==== test/psw_link_properties.sv ====
// checker: watchdog link properties
`timescale 1ns/1ns
module psw_link_properties
    import psw_pkg::*;
(
    input wire logic        clock,
    input wire logic        rst,
    input wire logic        cmdValid,
    input wire psw_cmd_e    cmdCode,
    input wire logic [31:0] cmdData,
    input wire logic        cmdAccepted,
    input wire logic        wdIrq,
    input wire logic        wdReset,
    input wire logic        safetyMode,
    input wire logic        overrun
);
    logic        w0Seen_q;
    logic [31:0] ovCnt_q;
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // ==========================================
    // helper: first service word seen, overrun length
    // ==========================================
    always_ff @(posedge clock) begin
        if (rst) begin
            w0Seen_q <= 1'b0;
        end else if (cmdValid) begin
            w0Seen_q <= (cmdCode == PSW_CMD_SERVICE) && (cmdData == SVC_WORD0);
        end
        ovCnt_q <= (rst || !overrun) ? 32'h0 : ovCnt_q + 32'h1;
    end
    // ==========================================
    // properties
    // ==========================================
    a_reset_state_off: assert property ($fell(rst) |-> !safetyMode && !overrun && !wdIrq)
        else $error("state not cleared after reset");
    a_lock_enters_safety: assert property (cmdValid && cmdCode == PSW_CMD_LOCK |=> safetyMode)
        else $error("lock did not enter safety mode");
    a_safety_never_left: assert property (safetyMode |=> safetyMode)
        else $error("safety mode left");
    a_irq_latched: assert property (wdIrq && !(cmdValid && cmdCode == PSW_CMD_ACK) |=> wdIrq)
        else $error("irq dropped without ack");
    a_ack_clears_irq: assert property (cmdValid && cmdCode == PSW_CMD_ACK && !overrun |=> !wdIrq)
        else $error("ack did not clear irq");
    a_irq_on_expiry: assert property ($rose(wdIrq) |-> overrun)
        else $error("irq without expiry");
    a_reset_event_pulse: assert property (wdReset |-> overrun ##1 !wdReset)
        else $error("reset event not a single pulse at expiry");
    a_restore_bounded: assert property (ovCnt_q <= RESTORE_CYC + 1)
        else $error("overrun outlasts restoration time");
    a_service_ends_overrun: assert property (overrun && cmdValid && cmdCode == PSW_CMD_SERVICE
        && cmdData == SVC_WORD1 && w0Seen_q |=> !overrun)
        else $error("service did not end overrun");
endmodule : psw_link_properties

// ==== test/processor_supervision_watchdog_bench.sv ====
// testbench: host and watchdog joined over the link, driven through apb
`timescale 1ns/1ns
module processor_supervision_watchdog_bench;
    import psw_pkg::*;
    logic clock, rst, psel, penable, pwrite, pready, pslverr, irq, irqToController;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, countNow, rv, c0;
    int          err_count, checks_done, n, rs;
    psw_link_if link();
    psw_host psw_host_inst(.clock(clock), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .link(link));
    psw_watchdog psw_watchdog_inst(.clock(clock), .rst(rst), .link(link),
        .irqToController(irqToController), .countNow(countNow));
    psw_link_properties psw_link_properties_inst(.clock(clock), .rst(rst),
        .cmdValid(link.cmdValid), .cmdCode(link.cmdCode), .cmdData(link.cmdData),
        .cmdAccepted(link.cmdAccepted), .wdIrq(link.wdIrq), .wdReset(link.wdReset),
        .safetyMode(link.safetyMode), .overrun(link.overrun));
    // ==========================================
    // helpers
    // ==========================================
    task automatic complete_run;
        if (err_count == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : complete_run
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
            err_count++;
        end
    endtask : chk
    task automatic fail;
        err_count++;
        complete_run();
    endtask : fail
    // one apb transfer; holds the request until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clock);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        k = 0;
        do begin @(posedge clock); k++; end while (pready !== 1'b1 && k < 20);
        if (k >= 20) fail();
        rv = prdata;
        psel <= 1'b0; penable <= 1'b0;
        #1;                                        // let the write settle before callers look
    endtask : apb
    // link command through data and command registers, waits for acceptance
    task automatic cmd(input psw_cmd_e c, input logic [31:0] d);
        int k;
        apb(1'b1, REG_DATA, d);
        apb(1'b1, REG_CMD, {29'h0, c});
        k = 0;
        while (link.cmdAccepted !== 1'b1 && k < 20) begin
            @(posedge clock);
            #1;
            k++;
        end
        if (k >= 20) fail();
        @(posedge clock);                          // edge at which the device consumes it
        #1;
    endtask : cmd
    task automatic svc;
        cmd(PSW_CMD_SERVICE, SVC_WORD0);
        cmd(PSW_CMD_SERVICE, SVC_WORD1);
    endtask : svc
    // waits for overrun to reach v, counts cycles and reset-event pulses
    task automatic waitOv(input logic v, input int lim);
        n = 0; rs = 0;
        while (link.overrun !== v && n < lim) begin
            @(posedge clock); #1; n++;
            rs += int'(link.wdReset === 1'b1);
        end
        if (n >= lim) fail();
    endtask : waitOv
    // ==========================================
    // clock, timeout, sequence
    // ==========================================
    initial begin clock = 1'b0; forever #25 clock = ~clock; end
    initial begin #(50 * 100000); fail(); end
    initial begin
        err_count = 0; checks_done = 0;
        rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h0; pwdata = 32'h0;
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        apb(1'b0, REG_STAT, 32'h0); chk(rv, 32'h0);
        apb(1'b0, 8'h20, 32'h0); chk(rv, 32'h0);
        apb(1'b1, REG_IRQ_MASK, 32'h2);
        cmd(PSW_CMD_SETPER, 32'd200); cmd(PSW_CMD_SETCFG, 32'h1); svc();
        chk(countNow <= 200 && countNow > 150, 1);
        c0 = countNow;
        cmd(PSW_CMD_SERVICE, 32'h1234); cmd(PSW_CMD_SERVICE, SVC_WORD1);
        chk(countNow < c0, 1);
        waitOv(1'b1, 400);
        apb(1'b0, REG_STAT, 32'h0); chk(rv, 32'h9);
        chk(irqToController, 1'b1); chk(irq, 1'b1);
        cmd(PSW_CMD_IRQEN, 32'h0);
        chk(irqToController, 1'b0); chk(link.wdIrq, 1'b1);
        cmd(PSW_CMD_IRQEN, 32'h1);
        svc(); chk(link.overrun, 1'b0); chk(link.wdIrq, 1'b1);
        cmd(PSW_CMD_ACK, 32'h0); chk(link.wdIrq, 1'b0);
        apb(1'b0, REG_IRQ_STAT, 32'h0); chk(rv, 32'h3);
        apb(1'b1, REG_IRQ_MASK, 32'h0); chk(irq, 1'b0);
        apb(1'b1, REG_IRQ_MASK, 32'h2); apb(1'b1, REG_IRQ_STAT, 32'h3); chk(irq, 1'b0);
        waitOv(1'b1, 400); waitOv(1'b0, 6000);
        chk(n >= RESTORE_CYC - 1 && n <= RESTORE_CYC + 1, 1);
        chk(countNow <= 200 && countNow > 190, 1);
        cmd(PSW_CMD_ACK, 32'h0); cmd(PSW_CMD_SETCFG, 32'h2); svc();
        waitOv(1'b1, 400); chk(rs, 1); chk(link.wdIrq, 1'b0);
        cmd(PSW_CMD_SETCFG, 32'h0); svc();
        repeat (400) @(posedge clock);
        #1 chk(link.overrun, 1'b0);
        cmd(PSW_CMD_SETCFG, 32'h1); svc(); cmd(PSW_CMD_LOCK, 32'h0);
        chk(link.safetyMode, 1'b1);
        cmd(PSW_CMD_SETPER, 32'd20000); cmd(PSW_CMD_SETCFG, 32'h0); svc();
        chk(countNow <= 200, 1);
        waitOv(1'b1, 400); chk(link.wdIrq, 1'b1);
        @(posedge clock); rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock); #1 chk(link.safetyMode, 1'b0);
        complete_run();
    end
endmodule : processor_supervision_watchdog_bench
